// ---- verilog/tsp_serial_port.sv ----
// Serial control and readout port of a touch screen converter.
//
// Behaviour
// - Result bits change on the falling edge of shift_clock.
// - serial_data_out is released while chip_select_n is high.
// - Busy is released while chip_select_n is high, driven only when low.
// - Control bits are sampled on the rising edge of shift_clock.
// - Chip select low starts work; serial traffic is ignored while high.
// - Conversion is paced only by shift_clock; host keeps clocking.
// - Acquisition begins on the fifth falling edge after the start bit.
// - Acquisition lasts three shift_clock cycles, then hold and conversion.
// - Pen interrupt is open drain and needs an external pull-up.
// - Result leaves MSB first, eleven more bits, then trailing zeros.
// - Both power mode bits set keeps the touch drivers on.
`timescale 1ns/10ps
`default_nettype none
module tsp_serial_port (
    // System clock domain.
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Serial link pins.
    input wire logic shift_clock,
    input wire logic chip_select_n,
    input wire logic serial_data_in,
    output var logic serial_data_out,
    output var logic serial_data_out_oe,
    output var logic busy_out,
    output var logic busy_oe,
    output var logic pen_touch_irq_n_out,
    output var logic pen_touch_irq_n_oe,
    // Touch sense input from the panel comparator.
    input wire logic pen_touched,
    // Conversion result supplied by the converter core.
    input wire logic [tsp_pkg::RESULT_W-1:0] result_data,
    input wire logic result_valid,
    output var logic result_ready,
    // Decoded control word.
    output var logic cmd_valid,
    output var logic [2:0] cmd_channel,
    output var logic cmd_mode,
    output var logic cmd_ser_dfr,
    output var logic [1:0] power_mode,
    // Converter control.
    output var logic acquire,
    output var logic drivers_on
);
    import tsp_pkg::*;

    // Link-side counter, shifters and phase flags are cleared on deselection; cmd_q, snap_q and their toggles are not.
    logic link_rst;
    logic [CNT_W-1:0] rise_cnt_q;
    logic [CMD_W-2:0] cmd_sr_q;
    logic [CMD_W-1:0] cmd_q;
    logic cmd_tog_q;
    logic acq_q;
    logic busy_q;
    logic dout_q;
    logic [RESULT_W-1:0] sr_q;
    logic [RESULT_W-1:0] snap_q;
    logic ack_tog_q;
    logic data_tog_s;

    // System-side state.
    logic [RESULT_W-1:0] data_q;
    logic data_tog_q;
    logic ack_tog_s;
    logic cmd_tog_s;
    logic cmd_tog_seen_q;
    logic acq_s;
    logic touch_s;
    logic [1:0] pd_q;
    logic drivers_q;

    assign link_rst = rst | chip_select_n;

    // Output drivers follow chip select directly so they turn on without a clock edge.
    assign serial_data_out = dout_q;
    assign serial_data_out_oe = ~chip_select_n & ~rst;
    assign busy_out = busy_q;
    assign busy_oe = ~chip_select_n & ~rst;

    // Open drain: only ever pulls low.
    assign pen_touch_irq_n_out = 1'b0;
    assign pen_touch_irq_n_oe = touch_s & ~drivers_q;

    // Rising edges since the start bit; zero means waiting for a start bit.
    always_ff @(posedge shift_clock or posedge link_rst) begin
        if (link_rst) begin
            rise_cnt_q <= CNT_IDLE;
        end else if (rise_cnt_q == CNT_IDLE || rise_cnt_q >= CNT_RESTART_MIN) begin
            if (serial_data_in) begin
                rise_cnt_q <= CNT_FIRST;
            end else if (rise_cnt_q != CNT_IDLE && rise_cnt_q != CNT_MAX) begin
                rise_cnt_q <= rise_cnt_q + 5'h01;
            end
        end else begin
            rise_cnt_q <= rise_cnt_q + 5'h01;
        end
    end

    // Control word capture; the toggle tells the system side a word is complete.
    always_ff @(posedge shift_clock or posedge link_rst) begin
        if (link_rst) begin
            cmd_sr_q <= '0;
        end else if (rise_cnt_q != CNT_IDLE && rise_cnt_q < CNT_CMD_LAST) begin
            cmd_sr_q <= {cmd_sr_q[CMD_W-3:0], serial_data_in};
        end
    end

    // The word and its toggle survive deselection so that the handshake stays consistent.
    always_ff @(posedge shift_clock or posedge rst) begin
        if (rst) begin
            cmd_q <= CMD_RESET;
            cmd_tog_q <= 1'b0;
        end else if (!chip_select_n && rise_cnt_q == CNT_CMD_LAST) begin
            cmd_q <= {cmd_sr_q, serial_data_in};
            cmd_tog_q <= ~cmd_tog_q;
        end
    end

    // Result snapshot taken from the system side by toggle handshake.
    always_ff @(posedge shift_clock or posedge rst) begin
        if (rst) begin
            snap_q <= RESULT_RESET;
            ack_tog_q <= 1'b0;
        end else if (data_tog_s != ack_tog_q) begin
            snap_q <= data_q;
            ack_tog_q <= data_tog_s;
        end
    end

    tsp_sync #(.W(1)) u_data_tog_sync (
        .clk(shift_clock),
        .rst(rst),
        .d(data_tog_q),
        .q(data_tog_s)
    );

    // Falling-edge phases: acquisition, one busy cycle, then the result.
    always_ff @(negedge shift_clock or posedge link_rst) begin
        if (link_rst) begin
            acq_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            acq_q <= rise_cnt_q >= CNT_ACQ_FIRST && rise_cnt_q < CNT_HOLD;
            busy_q <= rise_cnt_q == CNT_HOLD;
        end
    end

    // The shifter runs on its own so a new command may overlap the tail of a result.
    always_ff @(negedge shift_clock or posedge link_rst) begin
        if (link_rst) begin
            sr_q <= RESULT_RESET;
            dout_q <= 1'b0;
        end else if (rise_cnt_q == CNT_HOLD) begin
            sr_q <= snap_q;
            dout_q <= 1'b0;
        end else begin
            sr_q <= {sr_q[RESULT_W-2:0], 1'b0};
            dout_q <= sr_q[RESULT_W-1];
        end
    end

    // System side: result holding register for the link.
    assign result_ready = data_tog_q == ack_tog_s;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_q <= RESULT_RESET;
            data_tog_q <= 1'b0;
        end else if (ce && result_valid && result_ready) begin
            data_q <= result_data;
            data_tog_q <= ~data_tog_q;
        end
    end

    tsp_sync #(.W(4)) u_sys_sync (
        .clk(clk),
        .rst(rst),
        .d({ack_tog_q, cmd_tog_q, acq_q, pen_touched}),
        .q({ack_tog_s, cmd_tog_s, acq_s, touch_s})
    );

    // Decoded command, published when a fresh word arrives.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_tog_seen_q <= 1'b0;
            cmd_valid <= 1'b0;
            cmd_channel <= 3'h0;
            cmd_mode <= 1'b0;
            cmd_ser_dfr <= 1'b0;
            pd_q <= PD_RESET;
        end else if (ce) begin
            cmd_valid <= cmd_tog_s != cmd_tog_seen_q;
            if (cmd_tog_s != cmd_tog_seen_q) begin
                cmd_tog_seen_q <= cmd_tog_s;
                cmd_channel <= cmd_q[CMD_CH_HI:CMD_CH_LO];
                cmd_mode <= cmd_q[CMD_MODE_POS];
                cmd_ser_dfr <= cmd_q[CMD_SER_POS];
                pd_q <= cmd_q[CMD_PD_HI:CMD_PD_LO];
            end
        end
    end

    assign power_mode = pd_q;

    // Drivers stay on between conversions only when power-down is disabled.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drivers_q <= 1'b0;
            acquire <= 1'b0;
        end else if (ce) begin
            drivers_q <= pd_q == PD_KEEP_ON || acq_s;
            acquire <= acq_s;
        end
    end

    assign drivers_on = drivers_q;

    sequence acq_window_s;
        acq_q [*3] ##1 (!acq_q && busy_q);
    endsequence

    sequence acq_start_s;
        acq_q && !$past(acq_q);
    endsequence

    dout_shift_a: assert property (@(negedge shift_clock) disable iff (link_rst)
        (rise_cnt_q != CNT_HOLD) |=> (dout_q == $past(sr_q[RESULT_W-1])))
        else $error("serial output did not follow the shifter");
    dout_load_a: assert property (@(negedge shift_clock) disable iff (link_rst)
        (rise_cnt_q == CNT_HOLD) |=> (!dout_q && sr_q == $past(snap_q)))
        else $error("result not loaded at hold");
    dout_release_a: assert property (@(posedge clk) disable iff (rst)
        chip_select_n |-> !serial_data_out_oe)
        else $error("serial output driven while deselected");
    busy_release_a: assert property (@(posedge clk) disable iff (rst)
        chip_select_n |-> (!busy_oe && !$past(chip_select_n) || !busy_oe))
        else $error("busy driven while deselected");
    cmd_capture_a: assert property (@(posedge shift_clock) disable iff (link_rst)
        (rise_cnt_q == CNT_CMD_LAST) |=>
        (cmd_q == {$past(cmd_sr_q), $past(serial_data_in)}))
        else $error("control word capture wrong");
    deselect_idle_a: assert property (@(posedge shift_clock) disable iff (rst)
        chip_select_n |-> (rise_cnt_q == CNT_IDLE))
        else $error("serial traffic acted on while deselected");
    acq_begin_a: assert property (@(negedge shift_clock) disable iff (link_rst)
        (rise_cnt_q == CNT_ACQ_FIRST) |=> acq_start_s)
        else $error("acquisition did not begin on fifth falling edge");
    acq_length_a: assert property (@(negedge shift_clock) disable iff (link_rst)
        (rise_cnt_q == CNT_ACQ_FIRST) |-> ##1 acq_window_s)
        else $error("acquisition not three cycles before hold");
    busy_pulse_a: assert property (@(negedge shift_clock) disable iff (link_rst)
        busy_q |=> !busy_q)
        else $error("busy longer than one shift cycle");
    pen_drive_a: assert property (@(posedge clk) disable iff (rst)
        pen_touch_irq_n_oe |-> (!pen_touch_irq_n_out && !drivers_on))
        else $error("pen interrupt driven high or while drivers on");
    drivers_keep_a: assert property (@(posedge clk) disable iff (rst)
        (ce && power_mode == PD_KEEP_ON) |=> drivers_on)
        else $error("drivers off with power-down disabled");
endmodule
`default_nettype wire

// ---- inc/tsp_pkg.sv ----
// Shared constants for the touch converter serial port.
package tsp_pkg;
    localparam int RESULT_W = 12;
    localparam int CMD_W = 7;
    localparam int CNT_W = 5;
    // Rising-edge counts after the start bit, which is rising edge 1.
    localparam logic [4:0] CNT_IDLE = 5'h00;
    localparam logic [4:0] CNT_FIRST = 5'h01;
    localparam logic [4:0] CNT_CMD_LAST = 5'h07;
    localparam logic [4:0] CNT_ACQ_FIRST = 5'h05;
    localparam logic [4:0] CNT_ACQ_CYCLES = 5'h03;
    localparam logic [4:0] CNT_HOLD = CNT_ACQ_FIRST + CNT_ACQ_CYCLES;
    localparam logic [4:0] CNT_RESTART_MIN = 5'h0D;
    localparam logic [4:0] CNT_MAX = 5'h1F;
    // Control word field positions, after the start bit.
    localparam int CMD_CH_HI = 6;
    localparam int CMD_CH_LO = 4;
    localparam int CMD_MODE_POS = 3;
    localparam int CMD_SER_POS = 2;
    localparam int CMD_PD_HI = 1;
    localparam int CMD_PD_LO = 0;
    localparam logic [1:0] PD_KEEP_ON = 2'h3;
    localparam logic [1:0] PD_RESET = 2'h0;
    localparam logic [6:0] CMD_RESET = 7'h00;
    localparam logic [11:0] RESULT_RESET = 12'h000;
endpackage

// ---- verilog/tsp_sync.sv ----
// Two-stage synchroniser for levels and toggles entering a clock domain.
`timescale 1ns/10ps
`default_nettype none
module tsp_sync #(
    parameter int W = 1
) (
    // Destination clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Asynchronous level in, synchronised level out.
    input wire logic [W-1:0] d,
    output var logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/tsp_host.sv ----
// Host controller model that drives the serial link of the port.
`timescale 1ns/10ps
`default_nettype none
module tsp_host (
    // Link pins driven by the host.
    output var logic shift_clock,
    output var logic chip_select_n,
    output var logic serial_data_in,
    // Link pins read by the host.
    input wire logic serial_data_out,
    input wire logic busy_out
);
    initial begin
        shift_clock = 1'b0;
        chip_select_n = 1'b1;
        serial_data_in = 1'b0;
    end

    // The clock idles low outside frames so that no stray bits are shifted.
    // Samples are stored MSB first: the bit seen before rising edge i+1 lands at 23-i.
    task automatic frame(input logic [6:0] cmd, input int nclk,
                         output logic [23:0] dout, output logic [23:0] busy);
        logic [7:0] word;
        word = {1'b1, cmd};
        dout = '0;
        busy = '0;
        chip_select_n = 1'b0;
        for (int i = 0; i < nclk; i++) begin
            serial_data_in = (i < 8) ? word[7-i] : 1'b0;
            #40;
            dout[23-i] = serial_data_out;
            busy[23-i] = busy_out;
            shift_clock = 1'b1;
            #40;
            shift_clock = 1'b0;
        end
        #40;
        chip_select_n = 1'b1;
        // Once released, the data line no longer holds its last value.
        serial_data_in = ~serial_data_in;
        #80;
    endtask

    // Clock pulses with the chip deselected must leave the port untouched.
    task automatic stray(input int nclk);
        serial_data_in = 1'b1;
        repeat (nclk) begin
            #40;
            shift_clock = 1'b1;
            #40;
            shift_clock = 1'b0;
        end
        serial_data_in = 1'b0;
        #80;
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking testbench for the touch converter serial port.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import tsp_pkg::*;
    logic clk, rst, ce, pen_touched, result_valid, result_ready;
    logic [RESULT_W-1:0] result_data;
    logic shift_clock, chip_select_n, serial_data_in;
    logic serial_data_out, serial_data_out_oe, busy_out, busy_oe, pen_out, pen_oe;
    logic cmd_valid, cmd_mode, cmd_ser_dfr, acquire, drivers_on, acq_seen;
    logic [2:0] cmd_channel;
    logic [1:0] power_mode;
    wire logic pen_line;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    int cmd_seen = 0;

    // External pull-up on the open-drain pen line.
    assign pen_line = pen_oe ? pen_out : 1'b1;

    tsp_serial_port tsp_serial_port_i (.clk(clk), .rst(rst), .ce(ce),
        .shift_clock(shift_clock), .chip_select_n(chip_select_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .serial_data_out_oe(serial_data_out_oe), .busy_out(busy_out), .busy_oe(busy_oe),
        .pen_touch_irq_n_out(pen_out), .pen_touch_irq_n_oe(pen_oe),
        .pen_touched(pen_touched), .result_data(result_data), .result_valid(result_valid),
        .result_ready(result_ready), .cmd_valid(cmd_valid), .cmd_channel(cmd_channel),
        .cmd_mode(cmd_mode), .cmd_ser_dfr(cmd_ser_dfr), .power_mode(power_mode),
        .acquire(acquire), .drivers_on(drivers_on));

    tsp_host tsp_host_i (.shift_clock(shift_clock), .chip_select_n(chip_select_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .busy_out(busy_out));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic summarize;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // A run of a few frames needs well under a thousand cycles.
    // Outputs are sampled on the falling edge, away from the edge that launches them.
    always @(negedge clk) begin
        cycles++;
        if (cmd_valid === 1'b1) cmd_seen++;
        if (acquire === 1'b1) acq_seen = 1'b1;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic offer(input logic [11:0] w);
        @(negedge clk);
        result_data = w;
        result_valid = 1'b1;
        @(negedge clk);
        result_valid = 1'b0;
    endtask

    task automatic t_idle;
        check("oe idle", 24'h0, {serial_data_out_oe, busy_oe});
        check("pen idle", 24'h0, pen_line);
    endtask

    task automatic t_conv(input logic [6:0] cmd, input logic [11:0] w);
        logic [23:0] d, b;
        int n;
        n = cmd_seen;
        acq_seen = 1'b0;
        check("result_ready", 24'h1, result_ready);
        offer(w);
        tsp_host_i.frame(cmd, 24, d, b);
        check("data word", {12'h000, w}, {12'h000, d[14:3]});
        check("lead and tail", 24'h0, {d[15], d[2:0]});
        check("busy", 24'h008000, b);
        repeat (4) @(negedge clk);
        check("acquire seen", 24'h1, acq_seen);
        check("cmd count", 24'(n + 1), 24'(cmd_seen));
        check("fields", cmd, {cmd_channel, cmd_mode, cmd_ser_dfr, power_mode});
        check("drivers", cmd[1:0] == PD_KEEP_ON, drivers_on);
        check("pen line", cmd[1:0] == PD_KEEP_ON, pen_line);
        check("oe after", 24'h0, {serial_data_out_oe, busy_oe});
    endtask

    task automatic t_abort;
        logic [23:0] d, b;
        int n;
        n = cmd_seen;
        fork
            tsp_host_i.frame(7'h7F, 4, d, b);
            begin
                #100;
                check("oe selected", 2'h3, {serial_data_out_oe, busy_oe});
            end
        join
        tsp_host_i.stray(8);
        repeat (4) @(negedge clk);
        check("aborted cmd", 24'(n), 24'(cmd_seen));
        check("oe released", 24'h0, {serial_data_out_oe, busy_oe});
    endtask

    // With the enable low the system side holds still; the word is picked up later.
    task automatic t_freeze;
        logic [23:0] d, b;
        int n;
        n = cmd_seen;
        @(negedge clk);
        ce = 1'b0;
        tsp_host_i.frame(7'h2D, 16, d, b);
        repeat (4) @(negedge clk);
        check("frozen cmd", 24'(n), 24'(cmd_seen));
        check("frozen fields", 24'h064, {cmd_channel, cmd_mode, cmd_ser_dfr, power_mode});
        ce = 1'b1;
        repeat (4) @(negedge clk);
        check("thawed cmd", 24'(n + 1), 24'(cmd_seen));
        check("thawed fields", 24'h02D, {cmd_channel, cmd_mode, cmd_ser_dfr, power_mode});
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        pen_touched = 1'b1;
        result_valid = 1'b0;
        result_data = 12'h000;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        t_idle();
        t_conv(7'h51, 12'hA5C);
        t_abort();
        t_conv(7'h1B, 12'h3F1);
        t_conv(7'h64, 12'hFFE);
        t_freeze();
        summarize();
    end
endmodule
`default_nettype wire
